/* design/hs_pkg.sv */
// Constants and types for the hot-swap fault sequencer.
// Assumes a 50 MHz clock; all analog behaviour lives outside this logic.
// Notes on behaviour
// - Start after lockout 150ms, enable 10us, no retry
// - Slow detector idle during startup
// - Startup gate drive is limited charge
// - Fast hit in startup selects 70uA discharge
// - Fast hit at startup end is fault
// - Slow fault discharges gate at 200uA
// - Slow detector integrates up and down
// - Fast hit in normal forces 1mA discharge
// - Any fault drops status; full variant enables pulldown
// - Extra gate cap released only in fast discharge
// - Latched mode waits for enable low pulse
// - Autoretry ignores enable low pulses
// - Autoretry waits retry timeout then restarts
// - Single-timer retry is 32x startup
// - Retry pin strapped high selects latched
// - Full variant sets both times independently
// - Fast threshold strap: ground on, supply off
// - Status high only in clean normal run
// - Supply dip resets control state
package hs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LOCKOUT_MS = 150;
  localparam int unsigned ENABLE_US = 10;
  localparam int unsigned SLOW_US = 20;
  localparam int unsigned RELATCH_US = 20;
  localparam int unsigned RETRY_RATIO = 32;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned LOCKOUT_CYC = LOCKOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned ENABLE_CYC = ENABLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SLOW_CYC = SLOW_US * (CLK_HZ / 1_000_000);
  localparam logic [CNT_W-1:0] ONE = 32'h0000_0001;
  localparam logic [CNT_W-1:0] ZERO = 32'h0000_0000;
  // Gate drive modes seen by the analog stage
  typedef enum logic [2:0] {
    GATE_OFF = 3'h0,
    GATE_CHARGE = 3'h1,
    GATE_REG_DIS = 3'h2,
    GATE_SLOW_DIS = 3'h3,
    GATE_FAST_DIS = 3'h4
  } gate_mode_t;
  typedef enum logic [4:0] {
    ST_WAIT = 5'h01,
    ST_START = 5'h02,
    ST_RUN = 5'h04,
    ST_RETRY = 5'h08,
    ST_LATCH = 5'h10
  } seq_state_t;
endpackage

/* design/slow_if.sv */
// Link between sequencer and slow integrating detector.
// Assumes both ends share mclk_in.
`timescale 1ns/1ps
interface slow_if;
  logic arm;
  logic over;
  logic [hs_pkg::CNT_W-1:0] limit;
  logic trip;
  modport seq (output arm, output over, output limit, input trip);
  modport det (input arm, input over, input limit, output trip);
endinterface

/* design/slow_integrator.sv */
// Up/down integrator for the slow overcurrent detector.
// Assumes arm drops outside normal operation so the count restarts clean.
`timescale 1ns/1ps
module slow_integrator (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  slow_if.det sl
);
  logic [hs_pkg::CNT_W-1:0] acc_reg;

  // Above threshold counts up, below counts down, floored at zero
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_reg <= hs_pkg::ZERO;
    end else if (ce_in) begin
      if (!sl.arm) begin
        acc_reg <= hs_pkg::ZERO;
      end else if (sl.over) begin
        if (acc_reg < sl.limit) acc_reg <= acc_reg + hs_pkg::ONE;
      end else if (acc_reg != hs_pkg::ZERO) begin
        acc_reg <= acc_reg - hs_pkg::ONE;
      end
    end
  end

  // Combinational so the sequencer acts in the same cycle the limit is met
  assign sl.trip = sl.arm && sl.over && (acc_reg + hs_pkg::ONE >= sl.limit);

  // A disarmed detector must hold nothing over into the next run
  disarm_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (ce_in && !sl.arm) |=> acc_reg == hs_pkg::ZERO) else $error("integrator counted while disarmed");
  acc_floor_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (ce_in && sl.arm && !sl.over && acc_reg == hs_pkg::ZERO) |=> acc_reg == hs_pkg::ZERO)
    else $error("integrator below zero");
endmodule // slow_integrator

/* design/hs_sequencer.sv */
// Top of the hot-swap sequencer: startup gating, fault handling, retry.
// Assumes comparator and strap inputs are synchronous to mclk_in.
`timescale 1ns/1ps
module hs_sequencer #(
  parameter logic [31:0] LOCKOUT_CYC = hs_pkg::LOCKOUT_CYC
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic supply_ok_in,
  input wire logic enable_in,
  input wire logic fast_over_in,
  input wire logic slow_over_in,
  input wire logic full_variant_in,
  input wire logic single_timer_in,
  input wire logic latched_variant_in,
  input wire logic retry_to_supply_in,
  input wire logic fast_threshold_to_supply_in,
  input wire logic [31:0] startup_cyc_in,
  input wire logic [31:0] retry_cyc_in,
  input wire logic [31:0] slow_cyc_in,
  output logic [2:0] gate_mode_out,
  output logic status_out,
  output logic status_oe_out,
  output logic load_line_discharge_out,
  output logic extra_gate_cap_switch_out,
  output logic fault_out
);
  hs_pkg::seq_state_t state_reg;
  hs_pkg::seq_state_t state_next;
  logic [31:0] lock_cnt_reg;
  logic [31:0] en_cnt_reg;
  logic [31:0] tmr_reg;
  logic slow_hit_reg;
  logic en_low_seen_reg;
  logic fast_ena;
  logic latched_mode;
  logic lock_done;
  logic en_done;
  logic [31:0] retry_len;
  logic [31:0] slow_lim;
  logic slow_sel;
  slow_if sl ();

  // Both fault states show the same pins, so the test is shared
  function automatic logic is_fault(input hs_pkg::seq_state_t s);
    return (s == hs_pkg::ST_RETRY) || (s == hs_pkg::ST_LATCH);
  endfunction

  // Latched mode comes from variant or retry-pin strap
  assign latched_mode = latched_variant_in || (full_variant_in && retry_to_supply_in);
  assign fast_ena = fast_over_in && !(full_variant_in && fast_threshold_to_supply_in);
  assign lock_done = lock_cnt_reg >= LOCKOUT_CYC;
  assign en_done = en_cnt_reg >= hs_pkg::ENABLE_CYC;
  // Single-timer parts derive retry from startup; full part has its own
  assign retry_len = full_variant_in ? retry_cyc_in : 32'(startup_cyc_in * hs_pkg::RETRY_RATIO);
  assign slow_lim = (slow_cyc_in == hs_pkg::ZERO) ? 32'(hs_pkg::SLOW_CYC) : slow_cyc_in;
  assign sl.arm = (state_reg == hs_pkg::ST_RUN);
  assign sl.over = slow_over_in;
  assign sl.limit = slow_lim;
  // Slow discharge when the integrator caused this fault; kept for the whole fault
  assign slow_sel = (state_reg == hs_pkg::ST_RUN && sl.trip && !fast_ena) ||
    (state_reg == state_next && slow_hit_reg);

  slow_integrator u_slow (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .sl(sl.det)
  );

  // Lockout qualification; a supply dip clears it
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lock_cnt_reg <= hs_pkg::ZERO;
    end else if (ce_in) begin
      if (!supply_ok_in) lock_cnt_reg <= hs_pkg::ZERO;
      else if (!lock_done) lock_cnt_reg <= lock_cnt_reg + hs_pkg::ONE;
    end
  end

  // Enable qualification counter
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_cnt_reg <= hs_pkg::ZERO;
    end else if (ce_in) begin
      if (!enable_in) en_cnt_reg <= hs_pkg::ZERO;
      else if (!en_done) en_cnt_reg <= en_cnt_reg + hs_pkg::ONE;
    end
  end

  // Enable low seen while latched off; a single low cycle sets it
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_low_seen_reg <= 1'b0;
    end else if (ce_in) begin
      if (state_reg != hs_pkg::ST_LATCH) en_low_seen_reg <= 1'b0;
      else if (!enable_in) en_low_seen_reg <= 1'b1;
    end
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hs_pkg::ST_WAIT: begin
        if (lock_done && en_done) state_next = hs_pkg::ST_START;
      end
      hs_pkg::ST_START: begin
        if (tmr_reg + hs_pkg::ONE >= startup_cyc_in) begin
          if (fast_ena) state_next = latched_mode ? hs_pkg::ST_LATCH : hs_pkg::ST_RETRY;
          else state_next = hs_pkg::ST_RUN;
        end
      end
      hs_pkg::ST_RUN: begin
        if (fast_ena || sl.trip) state_next = latched_mode ? hs_pkg::ST_LATCH : hs_pkg::ST_RETRY;
        else if (!enable_in) state_next = hs_pkg::ST_WAIT;
      end
      hs_pkg::ST_RETRY: begin
        if (tmr_reg + hs_pkg::ONE >= retry_len) state_next = hs_pkg::ST_WAIT;
      end
      hs_pkg::ST_LATCH: begin
        if (en_low_seen_reg && enable_in) state_next = hs_pkg::ST_WAIT;
      end
      default: state_next = hs_pkg::ST_WAIT;
    endcase
    if (!supply_ok_in) state_next = hs_pkg::ST_WAIT;
    if (!enable_in && state_reg == hs_pkg::ST_START) state_next = hs_pkg::ST_WAIT;
  end

  // State register
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) state_reg <= hs_pkg::ST_WAIT;
    else if (ce_in) state_reg <= state_next;
  end

  // Shared startup/retry timer, restarts on every state change
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) tmr_reg <= hs_pkg::ZERO;
    else if (ce_in) tmr_reg <= (state_next != state_reg) ? hs_pkg::ZERO : tmr_reg + hs_pkg::ONE;
  end

  // Remember which detector caused the fault; rewritten on every change so a startup fault never inherits it
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) slow_hit_reg <= 1'b0;
    else if (ce_in && state_next != state_reg)
      slow_hit_reg <= (state_reg == hs_pkg::ST_RUN) && sl.trip && !fast_ena;
  end

  // Registered pin drive; gate mode follows next state for prompt response
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gate_mode_out <= hs_pkg::GATE_OFF;
      status_out <= 1'b0;
      status_oe_out <= 1'b1;
      load_line_discharge_out <= 1'b0;
      extra_gate_cap_switch_out <= 1'b1;
      fault_out <= 1'b0;
    end else if (ce_in) begin
      case (state_next)
        hs_pkg::ST_START: gate_mode_out <= fast_ena ? hs_pkg::GATE_REG_DIS : hs_pkg::GATE_CHARGE;
        hs_pkg::ST_RUN: gate_mode_out <= hs_pkg::GATE_CHARGE;
        hs_pkg::ST_RETRY, hs_pkg::ST_LATCH: begin
          if (slow_sel)
            gate_mode_out <= hs_pkg::GATE_SLOW_DIS;
          else
            gate_mode_out <= hs_pkg::GATE_FAST_DIS;
        end
        default: gate_mode_out <= hs_pkg::GATE_OFF;
      endcase
      status_out <= (state_next == hs_pkg::ST_RUN);
      status_oe_out <= (state_next != hs_pkg::ST_RUN);
      fault_out <= is_fault(state_next);
      load_line_discharge_out <= full_variant_in && is_fault(state_next);
      // Released only for fast discharge so the slow path still sees the cap
      extra_gate_cap_switch_out <= !(full_variant_in && is_fault(state_next) && !slow_sel);
    end
  end

  sequence fast_in_run_s;
    ce_in && state_reg == hs_pkg::ST_RUN && fast_ena && supply_ok_in;
  endsequence

  fast_off_now_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    fast_in_run_s |=> gate_mode_out == hs_pkg::GATE_FAST_DIS) else $error("fast fault not fast off");
  status_clean_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    status_out |-> state_reg == hs_pkg::ST_RUN) else $error("status high outside run");
  fault_status_low_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    fault_out |-> !status_out && status_oe_out) else $error("status high in fault");
  supply_dip_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (ce_in && !supply_ok_in) |=> state_reg == hs_pkg::ST_WAIT) else $error("dip kept state");
  start_gate_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ($past(state_reg) == hs_pkg::ST_WAIT && state_reg == hs_pkg::ST_START) |-> $past(lock_done && en_done))
    else $error("startup began early");
  reg_dis_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (ce_in && state_reg == hs_pkg::ST_START && state_next == hs_pkg::ST_START && fast_ena)
    |=> gate_mode_out == hs_pkg::GATE_REG_DIS) else $error("no regulation discharge");
  retry_no_enable_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (state_reg == hs_pkg::ST_RETRY && supply_ok_in && tmr_reg + hs_pkg::ONE < retry_len && ce_in)
    |=> state_reg == hs_pkg::ST_RETRY) else $error("retry left early");
  latch_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (state_reg == hs_pkg::ST_LATCH && !en_low_seen_reg && supply_ok_in) |=> state_reg == hs_pkg::ST_LATCH)
    else $error("latch released without pulse");
  cap_slow_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    gate_mode_out == hs_pkg::GATE_SLOW_DIS |-> extra_gate_cap_switch_out)
    else $error("cap released in slow discharge");
  // Fast discharge floats the extra cap on the full part and only there
  cap_fast_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    gate_mode_out == hs_pkg::GATE_FAST_DIS |-> extra_gate_cap_switch_out == !$past(full_variant_in))
    else $error("cap state wrong in fast discharge");
endmodule // hs_sequencer

/* test/pass_fet_model.sv */
// Behavioural pass transistor and sense resistor for the sequencer bench.
// Assumes the gate drive codes of hs_pkg and the bench clock.
`timescale 1ns/1ps
module pass_fet_model (
  input wire logic mclk_in,
  input wire logic [2:0] gate_mode_in,
  input wire logic short_in,
  input wire logic hard_short_in,
  input wire logic overload_in,
  output logic fast_over_out,
  output logic slow_over_out
);
  logic [3:0] level_reg = 4'h0;
  // Coarse gate voltage: charge raises it, every discharge mode lowers it
  always_ff @(posedge mclk_in) begin
    if (gate_mode_in == hs_pkg::GATE_CHARGE && level_reg != 4'hf) begin
      level_reg <= level_reg + 4'h1;
    end else if (gate_mode_in != hs_pkg::GATE_CHARGE && level_reg != 4'h0) begin
      level_reg <= level_reg - 4'h1;
    end
  end
  // Load current needs an enhanced gate; a hard short ignores it on purpose
  assign fast_over_out = hard_short_in | (short_in & (level_reg != 4'h0));
  assign slow_over_out = overload_in & (level_reg != 4'h0);
endmodule // pass_fet_model

/* test/hot_swap_fault_sequencer_tb.sv */
// Self-checking bench for the hot-swap sequencer and its pass device.
// Assumes hs_pkg, the design files and pass_fet_model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAITF(c, n) begin k = 0; while ((c) !== 1'b1 && k < (n)) begin step(1); k++; end \
  if ((c) !== 1'b1) begin fails++; conclude(); end end
module hot_swap_fault_sequencer_tb;
  // Row fields: full latch rts fts slow, gate[2:0], cap pull fault
  typedef struct packed {
    logic full, latch, rts, fts, slow;
    logic [2:0] gate;
    logic cap, pull, fault;
  } row_t;
  logic mclk_in = 1'b0, sys_rst_in = 1'b1, supply_ok_in, enable_in, full_variant_in, latched_variant_in;
  logic retry_to_supply_in, fast_threshold_to_supply_in, fast_over_in, slow_over_in, short_cmd, hard_cmd, over_cmd;
  logic [31:0] retry_cyc_in = 32'h0000_012c;
  logic ce_in = 1'b1;
  logic [2:0] gate_mode_out;
  logic status_out, status_oe_out, load_line_discharge_out, extra_gate_cap_switch_out, fault_out;
  logic [10:0] rows [7] = '{11'h025, 11'h05d, 11'h423, 11'h45f, 11'h48c, 11'h225, 11'h523};
  row_t r;
  int fails = 0, n_compared = 0, k, cnt;
  // Short lockout keeps the run small; startup 40, slow trip 50 cycles
  hs_sequencer #(.LOCKOUT_CYC(32'h0000_0014)) uut (.mclk_in, .sys_rst_in, .ce_in, .supply_ok_in,
    .enable_in, .fast_over_in, .slow_over_in, .full_variant_in, .single_timer_in(!full_variant_in),
    .latched_variant_in, .retry_to_supply_in, .fast_threshold_to_supply_in, .startup_cyc_in(32'h0000_0028),
    .retry_cyc_in, .slow_cyc_in(32'h0000_0032), .gate_mode_out, .status_out, .status_oe_out,
    .load_line_discharge_out, .extra_gate_cap_switch_out, .fault_out);
  pass_fet_model fet (.mclk_in, .gate_mode_in(gate_mode_out), .short_in(short_cmd), .hard_short_in(hard_cmd),
    .overload_in(over_cmd), .fast_over_out(fast_over_in), .slow_over_out(slow_over_in));
  always #10 mclk_in = ~mclk_in;
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset with the far side quiet, check idle outputs, then power up
  task automatic restart(input logic full, input logic latch);
    sys_rst_in = 1'b1;
    {supply_ok_in, enable_in, short_cmd, hard_cmd, over_cmd} = 5'h00;
    full_variant_in = full;
    latched_variant_in = latch;
    step(5);
    `CHK({gate_mode_out, status_out, status_oe_out, load_line_discharge_out, extra_gate_cap_switch_out, fault_out}, 8'h0a)
    sys_rst_in = 1'b0;
    {supply_ok_in, enable_in} = 2'h3;
  endtask
  // Counts cycles spent in fault, optionally pulsing enable low meanwhile
  task automatic hold_len(input logic pulse);
    cnt = 0;
    while (fault_out === 1'b1 && cnt < 3000) begin
      enable_in = !(pulse && cnt >= 100 && cnt < 200);
      step(1);
      cnt++;
    end
  endtask
  initial begin
    for (int i = 0; i < 7; i++) begin
      r = row_t'(rows[i]);
      retry_to_supply_in = r.rts;
      fast_threshold_to_supply_in = r.fts;
      restart(r.full, r.latch);
      `WAITF(status_out, 700)
      `CHK(gate_mode_out, hs_pkg::GATE_CHARGE)
      if (r.slow) begin
        over_cmd = 1'b1;
        `WAITF(fault_out, 200)
      end else begin
        short_cmd = 1'b1;
        step(1);
      end
      `CHK(gate_mode_out, r.gate)
      `CHK(status_out, !r.fault)
      `CHK(load_line_discharge_out, r.pull)
      `CHK(extra_gate_cap_switch_out, r.cap)
      `CHK(fault_out, r.fault)
    end
    retry_to_supply_in = 1'b0;
    fast_threshold_to_supply_in = 1'b0;
    // Charging waits for the full enable qualification
    restart(1'b0, 1'b0);
    step(490);
    `CHK(gate_mode_out, hs_pkg::GATE_OFF)
    `WAITF(gate_mode_out == hs_pkg::GATE_CHARGE, 30)
    step(3);
    // Inrush regulation; overload during startup must not count
    {short_cmd, over_cmd} = 2'h3;
    step(1);
    `CHK(gate_mode_out, hs_pkg::GATE_REG_DIS)
    short_cmd = 1'b0;
    `WAITF(gate_mode_out == hs_pkg::GATE_CHARGE, 20)
    `WAITF(status_out, 60)
    step(40);
    `CHK(fault_out, 1'b0)
    `WAITF(fault_out, 30)
    `CHK(gate_mode_out, hs_pkg::GATE_SLOW_DIS)
    // Enable pulses in autoretry must not shorten the 32x off time
    hold_len(1'b1);
    `CHK(cnt > 1277 && cnt < 1283, 1'b1)
    `WAITF(gate_mode_out == hs_pkg::GATE_CHARGE, 600)
    // A short that outlasts a retried startup stays in fast discharge after a slow fault
    `WAITF(gate_mode_out == hs_pkg::GATE_CHARGE, 600)
    hard_cmd = 1'b1;
    `WAITF(fault_out, 60)
    `CHK(gate_mode_out, hs_pkg::GATE_FAST_DIS)
    step(2);
    `CHK(gate_mode_out, hs_pkg::GATE_FAST_DIS)
    // Net excess trips, short bursts at low duty do not
    restart(1'b0, 1'b0);
    `WAITF(status_out, 700)
    for (cnt = 0; cnt < 300; cnt++) begin
      over_cmd = (cnt % 4 == 0);
      step(1);
    end
    `CHK(fault_out, 1'b0)
    for (cnt = 0; cnt < 150 && fault_out !== 1'b1; cnt++) begin
      over_cmd = (cnt % 4 != 0);
      step(1);
    end
    `CHK({cnt > 90, fault_out}, 2'h3)
    // Supply dip in the run drops the gate and restarts lockout
    restart(1'b0, 1'b0);
    `WAITF(status_out, 700)
    // Clock enable low freezes the run even through a dip
    ce_in = 1'b0;
    supply_ok_in = 1'b0;
    step(3);
    `CHK({gate_mode_out, status_out}, 4'h3)
    ce_in = 1'b1;
    step(2);
    `CHK({gate_mode_out, status_out}, 4'h0)
    supply_ok_in = 1'b1;
    step(15);
    `CHK(gate_mode_out, hs_pkg::GATE_OFF)
    // Full variant keeps its own retry count
    restart(1'b1, 1'b0);
    `WAITF(status_out, 700)
    short_cmd = 1'b1;
    `WAITF(fault_out, 5)
    hold_len(1'b0);
    `CHK(cnt > 297 && cnt < 303, 1'b1)
    // Latched variant stays off until enable is held low, then restarts
    restart(1'b0, 1'b1);
    `WAITF(status_out, 700)
    short_cmd = 1'b1;
    `WAITF(fault_out, 5)
    short_cmd = 1'b0;
    step(1500);
    `CHK(fault_out, 1'b1)
    enable_in = 1'b0;
    step(1000);
    enable_in = 1'b1;
    `WAITF(gate_mode_out == hs_pkg::GATE_CHARGE, 700)
    conclude();
  end
endmodule // hot_swap_fault_sequencer_tb
